// ==== design/dss_pkg.sv ====
// Shared constants and types for the shutdown sequencer and power-on reset
package dss_pkg;

  // ----------------------------------------
  // Bus geometry
  // ----------------------------------------
  localparam int ADDR_W = 10; // Byte address width, index times four
  localparam int DATA_W = 32; // Bus data width
  localparam int REG_W = 16; // Codec register width

  // ----------------------------------------
  // Register indices (byte address is four times these)
  // ----------------------------------------
  localparam logic [7:0] IDX_BIAS = 8'h04;
  localparam logic [7:0] IDX_REF = 8'h05;
  localparam logic [7:0] IDX_MIXER = 8'h0D;
  localparam logic [7:0] IDX_PHONE_GAIN = 8'h0E;
  localparam logic [7:0] IDX_LINE_GAIN = 8'h0F;
  localparam logic [7:0] IDX_CONVERTER = 8'h12;
  localparam logic [7:0] IDX_CLOCKS = 8'h16;
  localparam logic [7:0] IDX_SERVO = 8'h43;
  localparam logic [7:0] IDX_PHONE_OUT = 8'h5A;
  localparam logic [7:0] IDX_LINE_OUT = 8'h5E;
  localparam logic [7:0] IDX_PUMP = 8'h62;
  localparam logic [7:0] IDX_LAUNCH = 8'h6F;
  localparam logic [7:0] IDX_STATUS = 8'h70;

  // ----------------------------------------
  // Storage slots of the register array
  // ----------------------------------------
  localparam int NUM_SLOTS = 12; // Eleven codec registers and the launch register
  localparam logic [3:0] SLOT_LAUNCH = 4'hB;
  localparam logic [3:0] SLOT_STATUS = 4'hC;
  localparam logic [3:0] SLOT_NONE = 4'hF;
  localparam logic [15:0] REG_RST = 16'h0000; // Default of every stored register

  // ----------------------------------------
  // Launch and status fields
  // ----------------------------------------
  localparam int LAUNCH_IDX_LSB = 0;
  localparam int LAUNCH_IDX_W = 7;
  localparam int LAUNCH_START_BIT = 8;
  localparam int LAUNCH_ABORT_BIT = 9;
  localparam logic [6:0] SHUT_FIRST = 7'h20; // First shutdown step
  localparam logic [6:0] SHUT_LAST = 7'h30; // Last shutdown step
  localparam int STATUS_BUSY_BIT = 0;
  localparam int STATUS_POR_BIT = 1;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam real CLK_MHZ = 50.0;
  localparam real TPOR_US = 10.6; // Least power-on reset hold
  localparam real DLY_CODE0_MS = 0.5625;
  localparam real DLY_CODE9_MS = 32.5;
  localparam real DLY_CODEC_MS = 256.5;
  localparam int TPOR_CYC = int'($ceil(TPOR_US * CLK_MHZ));
  localparam int DLY_CODE0_CYC = int'($ceil(DLY_CODE0_MS * 1000.0 * CLK_MHZ));
  localparam int DLY_CODE9_CYC = int'($ceil(DLY_CODE9_MS * 1000.0 * CLK_MHZ));
  localparam int DLY_CODEC_CYC = int'($ceil(DLY_CODEC_MS * 1000.0 * CLK_MHZ));
  localparam logic [3:0] DCODE_0 = 4'h0;
  localparam logic [3:0] DCODE_9 = 4'h9;
  localparam logic [3:0] DCODE_C = 4'hC;
  localparam int CNT_W = 24; // Wide enough for the longest delay

  // ----------------------------------------
  // Bus responses
  // ----------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  // One program step: target, field, value, delay code, last flag
  typedef struct packed {
    logic [7:0] reg_idx;
    logic [3:0] width;
    logic [3:0] start;
    logic [7:0] data;
    logic [3:0] dly;
    logic last_step_flag;
  } dss_step_s;

  // Sequencer states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WRITE = 3'b010,
    ST_WAIT = 3'b100
  } dss_state_e;

endpackage

// ==== design/dss_top.sv ====
// Default shutdown program sequencer with power-on reset gating
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ps

// How it works
// - Writing 0120h to launch starts step 32
// - Whole program lasts about 297ms
// - Step 32: line outputs field 77h
// - Step 33: phone outputs field 77h
// - Step 34: phone outputs field 00h
// - Step 35: line outputs field 00h
// - Step 36: servo channels cleared
// - Step 37: charge pump off
// - Step 38: both converters off
// - Step 39: dsp clock off
// - Step 40: phone gain stages off
// - Step 41: line gain stages off
// - Step 42: output mixers off
// - Step 43: master bias off
// - Step 44: reference ramp select 10
// - Step 45: reference buffer off, 256.5ms
// - Step 46: reference buffer off, 32.5ms
// - Step 47: low byte of reference register cleared
// - Step 48: biases off, then stop
// - Writes discarded while power-on reset holds
// - Defaults present and writes accepted after release
// - Reset held at least 10.6us
// - Running flag high while program runs
module dss_top #(
  parameter int DLY0_CYC = dss_pkg::DLY_CODE0_CYC,
  parameter int DLY9_CYC = dss_pkg::DLY_CODE9_CYC,
  parameter int DLYC_CYC = dss_pkg::DLY_CODEC_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [dss_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [dss_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [dss_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [dss_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic supply_a_ok,
  input wire logic supply_d_ok,
  output logic sequencer_running_flag,
  output logic por_active
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [dss_pkg::REG_W-1:0] regs_r [dss_pkg::NUM_SLOTS]; // Register array
  logic aw_full_r; // Write address held
  logic w_full_r; // Write data held
  logic [dss_pkg::ADDR_W-1:0] aw_addr_r;
  logic [dss_pkg::DATA_W-1:0] w_data_r;
  logic [3:0] w_strb_r;
  logic awready_r;
  logic wready_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic arready_r;
  logic rvalid_r;
  logic [1:0] rresp_r;
  logic [dss_pkg::DATA_W-1:0] rdata_r;
  logic [1:0] sup_meta_r; // First synchroniser stage
  logic [1:0] sup_sync_r; // Second synchroniser stage
  logic [9:0] por_cnt_r; // Cycles since both supplies good
  logic por_r; // Internal reset held
  dss_pkg::dss_state_e state_r;
  logic [6:0] step_idx_r; // Current program index
  logic [dss_pkg::CNT_W-1:0] dly_cnt_r; // Remaining wait cycles
  logic busy_r;
  logic wr_fire; // Both halves of a write held
  logic [3:0] wr_slot; // Slot of the write
  logic host_wr; // Write that may change state
  logic launch_go; // Valid launch request
  logic launch_abort; // Abort request
  logic [6:0] launch_idx; // Requested start step
  dss_pkg::dss_step_s step; // Current step
  logic [3:0] step_slot; // Slot of the step target
  logic [dss_pkg::REG_W-1:0] step_mask; // Field mask of the step
  logic [dss_pkg::REG_W-1:0] step_val; // Shifted step value
  logic [dss_pkg::REG_W-1:0] host_mask; // Byte lane mask of the write

  // ----------------------------------------
  // Decode functions
  // ----------------------------------------
  // Maps a register index to its storage slot
  function automatic logic [3:0] slot_of(input logic [7:0] idx);
    case (idx)
      dss_pkg::IDX_BIAS: slot_of = 4'h0;
      dss_pkg::IDX_REF: slot_of = 4'h1;
      dss_pkg::IDX_MIXER: slot_of = 4'h2;
      dss_pkg::IDX_PHONE_GAIN: slot_of = 4'h3;
      dss_pkg::IDX_LINE_GAIN: slot_of = 4'h4;
      dss_pkg::IDX_CONVERTER: slot_of = 4'h5;
      dss_pkg::IDX_CLOCKS: slot_of = 4'h6;
      dss_pkg::IDX_SERVO: slot_of = 4'h7;
      dss_pkg::IDX_PHONE_OUT: slot_of = 4'h8;
      dss_pkg::IDX_LINE_OUT: slot_of = 4'h9;
      dss_pkg::IDX_PUMP: slot_of = 4'hA;
      dss_pkg::IDX_LAUNCH: slot_of = dss_pkg::SLOT_LAUNCH;
      dss_pkg::IDX_STATUS: slot_of = dss_pkg::SLOT_STATUS;
      default: slot_of = dss_pkg::SLOT_NONE;
    endcase
  endfunction

  // Byte address to slot; misaligned addresses miss
  function automatic logic [3:0] addr_slot(input logic [dss_pkg::ADDR_W-1:0] a);
    if (a[1:0] != 2'h0)
    begin
      addr_slot = dss_pkg::SLOT_NONE;
    end
    else
    begin
      addr_slot = slot_of(a[9:2]);
    end
  endfunction

  // Fixed shutdown program
  function automatic dss_pkg::dss_step_s prog(input logic [6:0] i);
    case (i)
      7'h20: prog = '{8'h5E, 4'h8, 4'h0, 8'h77, dss_pkg::DCODE_0, 1'b0};
      7'h21: prog = '{8'h5A, 4'h8, 4'h0, 8'h77, dss_pkg::DCODE_0, 1'b0};
      7'h22: prog = '{8'h5A, 4'h8, 4'h0, 8'h00, dss_pkg::DCODE_0, 1'b0};
      7'h23: prog = '{8'h5E, 4'h8, 4'h0, 8'h00, dss_pkg::DCODE_0, 1'b0};
      7'h24: prog = '{8'h43, 4'h4, 4'h0, 8'h00, dss_pkg::DCODE_0, 1'b0};
      7'h25: prog = '{8'h62, 4'h1, 4'h0, 8'h00, dss_pkg::DCODE_0, 1'b0};
      7'h26: prog = '{8'h12, 4'h2, 4'h2, 8'h00, dss_pkg::DCODE_0, 1'b0};
      7'h27: prog = '{8'h16, 4'h1, 4'h1, 8'h00, dss_pkg::DCODE_0, 1'b0};
      7'h28: prog = '{8'h0E, 4'h2, 4'h0, 8'h00, dss_pkg::DCODE_0, 1'b0};
      7'h29: prog = '{8'h0F, 4'h2, 4'h0, 8'h00, dss_pkg::DCODE_0, 1'b0};
      7'h2A: prog = '{8'h0D, 4'h2, 4'h0, 8'h00, dss_pkg::DCODE_0, 1'b0};
      7'h2B: prog = '{8'h04, 4'h1, 4'h0, 8'h00, dss_pkg::DCODE_0, 1'b0};
      7'h2C: prog = '{8'h05, 4'h2, 4'h3, 8'h02, dss_pkg::DCODE_0, 1'b0};
      7'h2D: prog = '{8'h05, 4'h1, 4'h0, 8'h00, dss_pkg::DCODE_C, 1'b0};
      7'h2E: prog = '{8'h05, 4'h1, 4'h0, 8'h00, dss_pkg::DCODE_9, 1'b0};
      7'h2F: prog = '{8'h05, 4'h8, 4'h0, 8'h00, dss_pkg::DCODE_0, 1'b0};
      default: prog = '{8'h04, 4'h2, 4'h0, 8'h00, dss_pkg::DCODE_0, 1'b1};
    endcase
  endfunction

  // Delay code to wait cycles, less one for the count to zero
  function automatic logic [dss_pkg::CNT_W-1:0] dly_load(input logic [3:0] code);
    case (code)
      dss_pkg::DCODE_9: dly_load = dss_pkg::CNT_W'(DLY9_CYC - 1);
      dss_pkg::DCODE_C: dly_load = dss_pkg::CNT_W'(DLYC_CYC - 1);
      default: dly_load = dss_pkg::CNT_W'(DLY0_CYC - 1);
    endcase
  endfunction

  // ----------------------------------------
  // Combinational decode
  // ----------------------------------------
  assign wr_fire = aw_full_r & w_full_r & ~bvalid_r;
  assign wr_slot = addr_slot(aw_addr_r);
  assign host_wr = wr_fire & ~por_r;
  assign launch_idx = w_data_r[dss_pkg::LAUNCH_IDX_LSB +: dss_pkg::LAUNCH_IDX_W];

  // Launch and abort requests from a host write
  always_comb
  begin
    launch_go = 1'b0;
    launch_abort = 1'b0;
    if (host_wr && wr_slot == dss_pkg::SLOT_LAUNCH && w_strb_r[1])
    begin
      launch_abort = w_data_r[dss_pkg::LAUNCH_ABORT_BIT];
      // Start index 32 to 48 runs the shutdown program
      launch_go = w_data_r[dss_pkg::LAUNCH_START_BIT] & w_strb_r[0] &
                  (launch_idx >= dss_pkg::SHUT_FIRST) &
                  (launch_idx <= dss_pkg::SHUT_LAST);
    end
  end

  // Field mask and value of the current step
  always_comb
  begin
    step = prog(step_idx_r);
    step_slot = slot_of(step.reg_idx);
    step_mask = dss_pkg::REG_W'(((17'h00001 << step.width) - 17'h00001) << step.start);
    step_val = dss_pkg::REG_W'({8'h00, step.data} << step.start) & step_mask;
  end

  // Byte lane mask of a host write
  always_comb
  begin
    host_mask = {{8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
  end

  // ----------------------------------------
  // Supply synchroniser
  // ----------------------------------------
  // Two flip-flops before the supply levels are used
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sup_meta_r <= 2'h0;
      sup_sync_r <= 2'h0;
    end
    else
    begin
      sup_meta_r <= {supply_d_ok, supply_a_ok};
      sup_sync_r <= sup_meta_r;
    end
  end

  // ----------------------------------------
  // Power-on reset
  // ----------------------------------------
  // Held while a supply is low, then for the least hold time
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      por_cnt_r <= 10'h000;
      por_r <= 1'b1;
    end
    else if (sup_sync_r != 2'h3)
    begin
      // Either supply below threshold restarts the hold
      por_cnt_r <= 10'h000;
      por_r <= 1'b1;
    end
    else if (por_cnt_r < 10'(dss_pkg::TPOR_CYC - 1))
    begin
      por_cnt_r <= por_cnt_r + 10'h001;
    end
    else
    begin
      por_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // Write channels
  // ----------------------------------------
  // Write address capture
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_r <= 1'b0;
      awready_r <= 1'b1;
      aw_addr_r <= '0;
    end
    else if (s_axi_awvalid && awready_r)
    begin
      aw_full_r <= 1'b1;
      awready_r <= 1'b0;
      aw_addr_r <= s_axi_awaddr;
    end
    else if (wr_fire)
    begin
      aw_full_r <= 1'b0;
      awready_r <= 1'b1;
    end
  end

  // Write data capture
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_full_r <= 1'b0;
      wready_r <= 1'b1;
      w_data_r <= '0;
      w_strb_r <= 4'h0;
    end
    else if (s_axi_wvalid && wready_r)
    begin
      w_full_r <= 1'b1;
      wready_r <= 1'b0;
      w_data_r <= s_axi_wdata;
      w_strb_r <= s_axi_wstrb;
    end
    else if (wr_fire)
    begin
      w_full_r <= 1'b0;
      wready_r <= 1'b1;
    end
  end

  // Write response; unmapped, read-only or reset-time writes error
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_r <= 1'b0;
      bresp_r <= dss_pkg::RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid_r <= 1'b1;
      if (por_r || wr_slot >= dss_pkg::SLOT_STATUS)
      begin
        bresp_r <= dss_pkg::RESP_SLVERR;
      end
      else
      begin
        bresp_r <= dss_pkg::RESP_OKAY;
      end
    end
    else if (s_axi_bready)
    begin
      bvalid_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // Read channel
  // ----------------------------------------
  // One read at a time, answered the cycle after it is taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rresp_r <= dss_pkg::RESP_OKAY;
      rdata_r <= '0;
    end
    else if (s_axi_arvalid && arready_r)
    begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rresp_r <= dss_pkg::RESP_OKAY;
      rdata_r <= '0;
      case (addr_slot(s_axi_araddr))
        dss_pkg::SLOT_STATUS:
        begin
          rdata_r[dss_pkg::STATUS_BUSY_BIT] <= busy_r;
          rdata_r[dss_pkg::STATUS_POR_BIT] <= por_r;
        end
        dss_pkg::SLOT_NONE:
        begin
          rresp_r <= dss_pkg::RESP_SLVERR;
        end
        default:
        begin
          rdata_r[dss_pkg::REG_W-1:0] <= regs_r[addr_slot(s_axi_araddr)];
        end
      endcase
    end
    else if (rvalid_r && s_axi_rready)
    begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // Register array
  // ----------------------------------------
  // Defaults under reset; sequencer write lands after a host write
  always_ff @(posedge aclk)
  begin
    if (!aresetn || por_r)
    begin
      for (int k = 0; k < dss_pkg::NUM_SLOTS; k++)
      begin
        regs_r[k] <= dss_pkg::REG_RST;
      end
    end
    else
    begin
      if (host_wr && wr_slot < dss_pkg::SLOT_LAUNCH)
      begin
        regs_r[wr_slot] <= (regs_r[wr_slot] & ~host_mask) |
                           (w_data_r[dss_pkg::REG_W-1:0] & host_mask);
      end
      else if (host_wr && wr_slot == dss_pkg::SLOT_LAUNCH)
      begin
        // Start and abort are actions, only the index is kept
        regs_r[wr_slot] <= {9'h000, launch_idx & {7{w_strb_r[0]}}};
      end
      if (state_r == dss_pkg::ST_WRITE && step_slot != dss_pkg::SLOT_NONE)
      begin
        regs_r[step_slot] <= (regs_r[step_slot] & ~step_mask) | step_val;
      end
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  // Write a step, wait its delay, advance until the last step
  always_ff @(posedge aclk)
  begin
    if (!aresetn || por_r)
    begin
      state_r <= dss_pkg::ST_IDLE;
      step_idx_r <= dss_pkg::SHUT_FIRST;
      dly_cnt_r <= '0;
      busy_r <= 1'b0;
    end
    else if (launch_abort)
    begin
      // Abort stops the program wherever it is
      state_r <= dss_pkg::ST_IDLE;
      busy_r <= 1'b0;
    end
    else
    begin
      case (state_r)
        dss_pkg::ST_IDLE:
        begin
          if (launch_go)
          begin
            state_r <= dss_pkg::ST_WRITE;
            step_idx_r <= launch_idx;
            busy_r <= 1'b1;
          end
        end
        dss_pkg::ST_WRITE:
        begin
          if (step.last_step_flag)
          begin
            state_r <= dss_pkg::ST_IDLE;
            busy_r <= 1'b0;
          end
          else
          begin
            state_r <= dss_pkg::ST_WAIT;
            dly_cnt_r <= dly_load(step.dly);
          end
        end
        dss_pkg::ST_WAIT:
        begin
          if (dly_cnt_r == '0)
          begin
            state_r <= dss_pkg::ST_WRITE;
            step_idx_r <= step_idx_r + 7'h01;
          end
          else
          begin
            dly_cnt_r <= dly_cnt_r - 1'b1;
          end
        end
        default:
        begin
          state_r <= dss_pkg::ST_IDLE;
          busy_r <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;
  assign sequencer_running_flag = busy_r;
  assign por_active = por_r;

endmodule // dss_top

// ==== sim/dss_checker.sv ====
// Concurrent checks on the bus and power-on reset ports of the sequencer
`timescale 1ns/1ps
module dss_checker #(
  parameter int DLY0_CYC = 4,
  parameter int DLY9_CYC = 20,
  parameter int DLYC_CYC = 40
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [dss_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [dss_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [dss_pkg::DATA_W-1:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic supply_a_ok,
  input wire logic supply_d_ok,
  input wire logic sequencer_running_flag,
  input wire logic por_active
);
  // ----------------------------------------
  // Helper: cycles spent in power-on reset
  // ----------------------------------------
  logic [15:0] por_cnt_r; // Length of the current reset hold
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !por_active)
      por_cnt_r <= 16'h0000;
    else
      por_cnt_r <= por_cnt_r + 16'h0001;
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Address and data taken at one edge
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // Launch of the shutdown program while idle and out of reset
  sequence s_launch;
    s_wr_taken ##0 (s_axi_awaddr == 10'h1BC && s_axi_wdata[15:0] == 16'h0120
      && !por_active && !sequencer_running_flag);
  endsequence
  a_write_answer: assert property (s_wr_taken |-> ##2 s_axi_bvalid)
    else $error("write response missing");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
    else $error("read response missing");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_ready_busy: assert property ($rose(s_axi_bvalid) |->
    !$past(s_axi_awready) && !$past(s_axi_wready))
    else $error("write response before both halves taken");
  a_por_discard: assert property (s_wr_taken ##0 por_active ##1 por_active |=> s_axi_bresp == dss_pkg::RESP_SLVERR)
    else $error("write in reset not refused");
  a_por_read_zero: assert property (s_axi_arvalid && s_axi_arready && por_active |-> ##[1:2] (s_axi_rvalid && s_axi_rdata == 32'h00000000))
    else $error("register not at default in reset");
  a_launch_run: assert property (s_launch |-> ##2 sequencer_running_flag)
    else $error("launch did not start program");
  a_supply_por: assert property (!supply_a_ok || !supply_d_ok |-> ##[0:4] por_active)
    else $error("supply loss did not reset");
  a_por_length: assert property ($fell(por_active) |-> por_cnt_r >= 16'(dss_pkg::TPOR_CYC))
    else $error("reset hold too short");
endmodule // dss_checker

bind dss_top dss_checker #(.DLY0_CYC(DLY0_CYC), .DLY9_CYC(DLY9_CYC), .DLYC_CYC(DLYC_CYC)) u_chk (
  .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .supply_a_ok, .supply_d_ok,
  .sequencer_running_flag, .por_active
);

// ==== sim/dss_top_tb_top.sv ====
// Self-checking bench for the shutdown sequencer with a register model
`timescale 1ns/1ps
module dss_top_tb_top;
  // ----------------------------------------
  // Signals and model state
  // ----------------------------------------
  localparam int D0 = 4; // Short delays keep the run brief
  localparam int D9 = 20;
  localparam int DC = 40;
  localparam logic [1:0] OK = dss_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = dss_pkg::RESP_SLVERR;
  // Program steps 32..48 as {index, width, start bit, data}
  localparam logic [23:0] STEPS [17] = '{24'h5E8077, 24'h5A8077, 24'h5A8000, 24'h5E8000,
    24'h434000, 24'h621000, 24'h122200, 24'h161100, 24'h0E2000, 24'h0F2000, 24'h0D2000,
    24'h041000, 24'h052302, 24'h051000, 24'h051000, 24'h058000, 24'h042000};
  localparam logic [7:0] REGS [11] = '{8'h04, 8'h05, 8'h0D, 8'h0E, 8'h0F, 8'h12, 8'h16,
    8'h43, 8'h5A, 8'h5E, 8'h62};
  logic aclk = 1'b0;
  logic aresetn;
  logic [dss_pkg::ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [dss_pkg::DATA_W-1:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic supply_a_ok, supply_d_ok, sequencer_running_flag, por_active;
  logic [15:0] mdl [256]; // Expected register contents by index
  int n_mismatch = 0;
  int comparisons = 0;
  int run_cyc = 0; // Cycles seen with the program running
  int seed = 32'hB187;
  always #10 aclk = ~aclk;
  always @(posedge aclk)
    if (sequencer_running_flag === 1'b1)
      run_cyc <= run_cyc + 1;
  dss_top #(.DLY0_CYC(D0), .DLY9_CYC(D9), .DLYC_CYC(DC)) dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .supply_a_ok, .supply_d_ok,
    .sequencer_running_flag, .por_active
  );
  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task automatic finish_test;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic hang(input int n);
    if (n >= 2000)
    begin
      chk(0, 1, "wait ran out");
      finish_test;
    end
  endtask
  // ----------------------------------------
  // Bus master tasks
  // ----------------------------------------
  task automatic wr(input logic [7:0] i, input logic [15:0] d, input logic [1:0] er);
    int n;
    bit a, w;
    n = 0;
    a = 0;
    w = 0;
    s_axi_awaddr <= {i, 2'b00};
    s_axi_wdata <= {16'h0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (!a && s_axi_awready === 1'b1)
      begin
        a = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready === 1'b1)
      begin
        w = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (!(a && w && s_axi_bvalid === 1'b1) && n < 2000);
    hang(n);
    chk(32'(s_axi_bresp), 32'(er), "write response");
  endtask
  task automatic rd(input logic [7:0] i, input logic [15:0] e, input logic [1:0] er);
    int n;
    n = 0;
    s_axi_araddr <= {i, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_arready === 1'b1)
        s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1 && n < 2000);
    hang(n);
    chk(s_axi_rdata, {16'h0000, e}, "read data");
    chk(32'(s_axi_rresp), 32'(er), "read response");
  endtask
  // ----------------------------------------
  // Model and scenario helpers
  // ----------------------------------------
  task automatic check_all;
    foreach (REGS[k])
      rd(REGS[k], mdl[REGS[k]], OK);
  endtask
  task automatic wait_por(input logic lvl, output int n);
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
    end
    while (por_active !== lvl && n < 2000);
    hang(n);
  endtask
  task automatic launch(input int first);
    int n, exp;
    logic [23:0] s;
    logic [15:0] m;
    exp = 1;
    for (int k = first; k < 48; k++)
      exp += 1 + (k == 45 ? DC : (k == 46 ? D9 : D0));
    foreach (REGS[k])
    begin
      mdl[REGS[k]] = 16'($random(seed));
      wr(REGS[k], mdl[REGS[k]], OK);
    end
    run_cyc <= 0;
    wr(8'h6F, 16'h0100 | 16'(first), OK);
    m = first == 32 ? (mdl[8'h5E] & 16'hFF00) | 16'h0077 : mdl[8'h5E];
    rd(8'h5E, m, OK);
    rd(8'h70, 16'h0001, OK);
    n = 0;
    while (sequencer_running_flag !== 1'b0 && n < 2000)
    begin
      @(posedge aclk);
      n++;
    end
    hang(n);
    chk(32'(run_cyc >= exp - 2 && run_cyc <= exp + 2), 1, "program length");
    for (int k = first - 32; k < 17; k++)
    begin
      s = STEPS[k];
      m = 16'(((1 << s[15:12]) - 1) << s[11:8]);
      mdl[s[23:16]] = (mdl[s[23:16]] & ~m) | (16'(s[7:0]) << s[11:8] & m);
    end
    rd(8'h6F, 16'(first), OK);
    check_all;
    rd(8'h70, 16'h0000, OK);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    int n;
    foreach (mdl[k])
      mdl[k] = 16'h0000;
    {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {supply_a_ok, supply_d_ok, aresetn} = '0;
    s_axi_wstrb = 4'hF;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    wr(8'h04, 16'h1234, ERR);
    rd(8'h04, 16'h0000, OK);
    supply_a_ok <= 1'b1;
    supply_d_ok <= 1'b1;
    wait_por(1'b0, n);
    chk(32'(n >= 530 && n <= 540), 1, "reset hold");
    check_all;
    $display("test power-on done");
    launch(32);
    $display("test launch at 32 done");
    launch(33);
    $display("test launch at 33 done");
    wr(8'h6F, 16'h0120, OK);
    wr(8'h6F, 16'h0200, OK);
    rd(8'h70, 16'h0000, OK);
    wr(8'h01, 16'h00FF, ERR);
    rd(8'h01, 16'h0000, ERR);
    wr(8'h70, 16'h0001, ERR);
    $display("test refused access done");
    supply_d_ok <= 1'b0;
    wait_por(1'b1, n);
    chk(32'(n <= 4), 1, "supply loss");
    wr(8'h05, 16'h00FF, ERR);
    supply_d_ok <= 1'b1;
    wait_por(1'b0, n);
    foreach (mdl[k])
      mdl[k] = 16'h0000;
    check_all;
    $display("test second reset done");
    finish_test;
  end
endmodule // dss_top_tb_top
